//--- rtl/ident_words.sv
// Identify word register bank: timing modes, security, power, capacity.
// Assumes an APB master on pclk; software loads the card state and the
// identify words are formed from it and read back over the same bus.
//
// Design decisions made here: the address map and the APB slave port.
module ident_words
    import ident_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Security command outcome
    output logic cmd_abort
);
    // -----------------------------------------------------------------
    // Bus handshake
    // -----------------------------------------------------------------
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic cmd_abort_q;
    logic acc;
    logic done;
    logic wr;
    logic known;
    logic writable;
    logic [31:0] rdata;

    // One wait state: data is captured in the first access cycle.
    assign acc = psel && penable && !pready_q;
    assign done = psel && penable && pready_q;
    assign wr = done && pwrite && writable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= acc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (acc) begin
            prdata_q <= (pwrite || !known) ? 32'h0000_0000 : rdata;
            pslverr_q <= !known || (pwrite && !writable);
        end
    end

    // -----------------------------------------------------------------
    // Software state
    // -----------------------------------------------------------------
    logic true_ide_q;
    logic udma_cap_q;
    logic [2:0] udma_max_q;
    logic [2:0] udma_mode_q;
    logic udma_on_q;
    logic mdma_on_q;
    logic [15:0] mpw_rev_q;
    logic [47:0] max_lba_q;
    logic [15:0] trim_lim_q;
    sec_cfg_t sec_q;
    power_t pwr_q;
    adv_ide_t ide_q;
    adv_pc_t pc_q;
    adv_ide_t ide_w;
    adv_pc_t pc_w;

    assign ide_w = adv_ide_t'(pwdata[11:0]);
    assign pc_w = adv_pc_t'(pwdata[15:0]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            true_ide_q <= 1'b0;
            udma_cap_q <= 1'b0;
            udma_max_q <= 3'h0;
        end else if (wr && paddr == OFF_MODE) begin
            true_ide_q <= pwdata[0];
            udma_cap_q <= pwdata[1];
            udma_max_q <= (pwdata[4:2] > UDMA_TOP) ? UDMA_TOP : pwdata[4:2];
        end
    end

    // DMA mode exclusion
    // Ultra DMA wins when both are requested in one write, if its mode is within udma_max_q.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            udma_mode_q <= 3'h0;
            udma_on_q <= 1'b0;
            mdma_on_q <= 1'b0;
        end else if (wr && paddr == OFF_XFER) begin
            if (pwdata[3] && pwdata[2:0] <= udma_max_q) begin
                udma_mode_q <= pwdata[2:0];
                udma_on_q <= 1'b1;
                mdma_on_q <= 1'b0;
            end else if (pwdata[4]) begin
                udma_on_q <= 1'b0;
                mdma_on_q <= 1'b1;
            end else if (!pwdata[3]) begin
                udma_on_q <= 1'b0;
                mdma_on_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mpw_rev_q <= 16'h0000;
            trim_lim_q <= 16'h0000;
        end else if (wr && paddr == OFF_MPW_REV) begin
            mpw_rev_q <= pwdata[15:0];
        end else if (wr && paddr == OFF_TRIM_LIM) begin
            trim_lim_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            max_lba_q <= 48'h0000_0000_0000;
        end else if (wr && paddr == OFF_LBA_LO) begin
            max_lba_q[31:0] <= pwdata;
        end else if (wr && paddr == OFF_LBA_HI) begin
            max_lba_q[47:32] <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_q <= '0;
            pwr_q <= '0;
        end else if (wr && paddr == OFF_SEC_CTRL) begin
            sec_q <= sec_cfg_t'(pwdata[5:0]);
        end else if (wr && paddr == OFF_POWER) begin
            pwr_q <= power_t'({pwdata[15], pwdata[13:0]});
        end
    end

    // PIO and multiword DMA support and selection codes
    // A field written with a reserved code keeps its previous value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ide_q <= '0;
        end else if (wr && paddr == OFF_ADV_IDE) begin
            if (ide_w.pio_sup <= ADV_IDE_TOP) begin
                ide_q.pio_sup <= ide_w.pio_sup;
            end
            if (ide_w.mdma_sup <= ADV_IDE_TOP) begin
                ide_q.mdma_sup <= ide_w.mdma_sup;
            end
            if (ide_w.pio_sel <= ADV_IDE_TOP) begin
                ide_q.pio_sel <= ide_w.pio_sel;
            end
            if (ide_w.mdma_sel <= ADV_IDE_TOP) begin
                ide_q.mdma_sel <= ide_w.mdma_sel;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= '0;
        end else if (wr && paddr == OFF_ADV_PC) begin
            if (pc_w.io_cyc <= PC_CYC_TOP) begin
                pc_q.io_cyc <= pc_w.io_cyc;
            end
            if (pc_w.mem_cyc <= PC_CYC_TOP) begin
                pc_q.mem_cyc <= pc_w.mem_cyc;
            end
            if (pc_w.io_udma <= UDMA_TOP) begin
                pc_q.io_udma <= pc_w.io_udma;
            end
            if (pc_w.mem_udma <= UDMA_TOP) begin
                pc_q.mem_udma <= pc_w.mem_udma;
            end
            if (pc_w.udma_sel <= UDMA_TOP) begin
                pc_q.udma_sel <= pc_w.udma_sel;
            end
            pc_q.modes_valid <= pc_w.modes_valid;
        end
    end

    // -----------------------------------------------------------------
    // Security attempt counter
    // -----------------------------------------------------------------
    logic [3:0] attempts_q;
    logic expired_q;
    logic abort_seen_q;
    logic cmd_wr;
    logic sec_req;

    assign cmd_wr = wr && paddr == OFF_SEC_CMD;
    assign sec_req = cmd_wr && (pwdata[1] || pwdata[2]);

    // Attempt expiry
    // Only presetn clears the expiry, standing in for power-on or hard reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            attempts_q <= ATTEMPTS_RST;
            expired_q <= 1'b0;
        end else if (cmd_wr && pwdata[0] && !expired_q) begin
            attempts_q <= attempts_q - 4'h1;
            expired_q <= attempts_q == 4'h1;
        end
    end

    // Abort while expired
    // A new refusal in the cycle of a clear keeps the sticky flag set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_abort_q <= 1'b0;
            abort_seen_q <= 1'b0;
        end else begin
            cmd_abort_q <= sec_req && expired_q;
            if (sec_req && expired_q) begin
                abort_seen_q <= 1'b1;
            end else if (wr && paddr == OFF_SEC_STAT && pwdata[5]) begin
                abort_seen_q <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // Identify words
    // -----------------------------------------------------------------
    logic [6:0] udma_sup_v;
    logic [6:0] udma_sel_v;
    logic [15:0] w88;
    logic [63:0] w_lba;
    logic [15:0] w128;
    logic [15:0] w160;
    logic [15:0] w163;
    logic [15:0] w164;

    for (genvar i = 0; i < UDMA_MODES; i++) begin : g_udma
        assign udma_sup_v[i] = udma_max_q >= 3'(i);
        assign udma_sel_v[i] = udma_on_q && udma_mode_q == 3'(i);
    end

    assign w88 = (true_ide_q && udma_cap_q) ?
        {1'b0, udma_sel_v, 1'b0, udma_sup_v} : 16'h0000;

    assign w_lba = {16'h0000, max_lba_q} + 64'h1;

    assign w128 = {7'h00, sec_q.level_max && sec_q.enabled, 2'b00,
        sec_q.enh_erase, expired_q, sec_q.frozen, sec_q.locked,
        sec_q.enabled, sec_q.capable};

    assign w160 = {pwr_q.power_desc_valid, 1'b0,
        pwr_q.no_level1_power_cmds, pwr_q.level1_power_cmds_disabled,
        pwr_q.max_ma};

    // Advanced selection reported
    // A chosen advanced multiword mode is hidden while Ultra DMA is on.
    assign w163 = {4'h0, udma_on_q ? 3'h0 : ide_q.mdma_sel, ide_q.pio_sel,
        ide_q.mdma_sup, ide_q.pio_sup};

    assign w164 = {pc_q.modes_valid, pc_q.udma_sel, pc_q.mem_udma,
        pc_q.io_udma, pc_q.mem_cyc, pc_q.io_cyc};

    // -----------------------------------------------------------------
    // Read decode
    // -----------------------------------------------------------------
    always_comb begin
        rdata = 32'h0000_0000;
        known = 1'b1;
        writable = 1'b1;
        case (paddr)
            OFF_MODE: rdata = {27'h0, udma_max_q, udma_cap_q, true_ide_q};
            OFF_XFER: rdata = {27'h0, mdma_on_q, udma_on_q, udma_mode_q};
            OFF_MPW_REV: rdata = {16'h0, mpw_rev_q};
            OFF_LBA_LO: rdata = max_lba_q[31:0];
            OFF_LBA_HI: rdata = {16'h0, max_lba_q[47:32]};
            OFF_TRIM_LIM: rdata = {16'h0, trim_lim_q};
            OFF_SEC_CTRL: rdata = {26'h0, sec_q};
            OFF_SEC_CMD: rdata = 32'h0000_0000;
            OFF_POWER: rdata = {16'h0, w160};
            OFF_ADV_IDE: rdata = {20'h0, ide_q};
            OFF_ADV_PC: rdata = {16'h0, pc_q};
            OFF_SEC_STAT: rdata = {26'h0, abort_seen_q, attempts_q, expired_q};
            default: begin
                writable = 1'b0;
                case (paddr)
                    OFF_W88: rdata = {16'h0, w88};
                    OFF_W92: rdata = {16'h0, mpw_rev_q};
                    OFF_W100: rdata = w_lba[31:0];
                    OFF_W102: rdata = w_lba[63:32];
                    OFF_W105: rdata = {16'h0, trim_lim_q};
                    OFF_W128: rdata = {16'h0, w128};
                    OFF_W160: rdata = {16'h0, w160};
                    OFF_W163: rdata = {16'h0, w163};
                    OFF_W164: rdata = {16'h0, w164};
                    OFF_W169: rdata = {16'h0, W169_VALUE};
                    OFF_W87: rdata = {16'h0, W87_VALUE};
                    default: known = 1'b0;
                endcase
            end
        endcase
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cmd_abort = cmd_abort_q;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_dma_exclusive: assert property (!(udma_on_q && mdma_on_q))
        else $error("Ultra DMA and multiword DMA both selected.");
    a_w88_gated: assert property (
        !(true_ide_q && udma_cap_q) |-> w88 == 16'h0000)
        else $error("Ultra DMA word not zero outside True IDE.");
    a_w88_onehot: assert property (
        $onehot0(w88[14:8]) && !w88[15] && (w88[14:8] != 7'h0) == (udma_on_q
        && true_ide_q && udma_cap_q))
        else $error("Ultra DMA selection bits malformed.");
    a_w88_cumulative: assert property (
        ((w88[6:0] + 7'h1) & w88[6:0]) == 7'h00 && !w88[7])
        else $error("Ultra DMA support bits not cumulative.");
    a_lba_plus_one: assert property (
        wr && paddr == OFF_LBA_LO |=> w_lba[31:0] == $past(pwdata) + 32'h1
        || $past(pwdata) == 32'hFFFF_FFFF)
        else $error("Capacity word is not the loaded value plus one.");
    a_sec_level: assert property (
        wr && paddr == OFF_SEC_CTRL |=> w128[8] == ($past(pwdata[4]) && $past(pwdata[1])))
        else $error("Security level bit wrong.");
    a_expire_abort: assert property (
        sec_req && expired_q |=> cmd_abort_q ##1 !cmd_abort_q || $past(sec_req))
        else $error("Security command not aborted after expiry.");
    a_expire_sticky: assert property (expired_q |=> expired_q)
        else $error("Expiry cleared without reset.");
    a_power_rsv: assert property (
        wr && paddr == OFF_POWER |=> w160 == {$past(pwdata[15]), 1'b0, $past(pwdata[13:0])})
        else $error("Power word reserved bit set.");
    a_pc_udma_code: assert property (
        w164[14:12] != 3'h7 && w164[8:6] != 3'h7)
        else $error("Reserved PC card Ultra DMA code reported.");
    a_apb_wait: assert property (acc |=> pready_q ##1 !pready_q)
        else $error("APB answer not one wait state.");

    c_udma_select: cover property (w88[14] && w88[6]);
    c_expired_abort: cover property (expired_q ##1 cmd_abort_q);
    c_bad_address: cover property (pslverr_q && pready_q);
endmodule

//--- common/ident_pkg.sv
// Constants and carrier types for the identify word register bank.
// Assumes a 32-bit APB master on pclk and byte addresses of 8 bits.
package ident_pkg;
    // -----------------------------------------------------------------
    // Register byte offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_XFER = 8'h04;
    localparam logic [7:0] OFF_MPW_REV = 8'h08;
    localparam logic [7:0] OFF_LBA_LO = 8'h0C;
    localparam logic [7:0] OFF_LBA_HI = 8'h10;
    localparam logic [7:0] OFF_TRIM_LIM = 8'h14;
    localparam logic [7:0] OFF_SEC_CTRL = 8'h18;
    localparam logic [7:0] OFF_SEC_CMD = 8'h1C;
    localparam logic [7:0] OFF_POWER = 8'h20;
    localparam logic [7:0] OFF_ADV_IDE = 8'h24;
    localparam logic [7:0] OFF_ADV_PC = 8'h28;
    localparam logic [7:0] OFF_W88 = 8'h40;
    localparam logic [7:0] OFF_W92 = 8'h44;
    localparam logic [7:0] OFF_W100 = 8'h48;
    localparam logic [7:0] OFF_W102 = 8'h4C;
    localparam logic [7:0] OFF_W105 = 8'h50;
    localparam logic [7:0] OFF_W128 = 8'h54;
    localparam logic [7:0] OFF_W160 = 8'h58;
    localparam logic [7:0] OFF_W163 = 8'h5C;
    localparam logic [7:0] OFF_W164 = 8'h60;
    localparam logic [7:0] OFF_W169 = 8'h64;
    localparam logic [7:0] OFF_W87 = 8'h68;
    localparam logic [7:0] OFF_SEC_STAT = 8'h6C;
    // -----------------------------------------------------------------
    // Field positions and limits
    // -----------------------------------------------------------------
    localparam int UDMA_MODES = 7;
    localparam int W88_SEL_LSB = 8;
    localparam logic [2:0] UDMA_TOP = 3'h6;
    localparam logic [2:0] ADV_IDE_TOP = 3'h2;
    localparam logic [2:0] PC_CYC_TOP = 3'h3;
    localparam logic [15:0] W87_VALUE = 16'h4000;
    localparam logic [15:0] W169_VALUE = 16'h0001;
    localparam logic [3:0] ATTEMPTS_RST = 4'h5;
    // -----------------------------------------------------------------
    // Carrier types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic enh_erase;
        logic level_max;
        logic frozen;
        logic locked;
        logic enabled;
        logic capable;
    } sec_cfg_t;
    typedef struct packed {
        logic power_desc_valid;
        logic no_level1_power_cmds;
        logic level1_power_cmds_disabled;
        logic [11:0] max_ma;
    } power_t;
    typedef struct packed {
        logic [2:0] mdma_sel;
        logic [2:0] pio_sel;
        logic [2:0] mdma_sup;
        logic [2:0] pio_sup;
    } adv_ide_t;
    typedef struct packed {
        logic modes_valid;
        logic [2:0] udma_sel;
        logic [2:0] mem_udma;
        logic [2:0] io_udma;
        logic [2:0] mem_cyc;
        logic [2:0] io_cyc;
    } adv_pc_t;
endpackage

//--- testbench/apb_host.sv
// Host model: an APB master that reads and loads the identify words.
// Assumes one pclk domain; the bench calls xfer for each transfer.
module apb_host
    import ident_pkg::*;
(
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Request is held until pready is seen high; the wait is bounded so a
    // slave that never answers is reported instead of hanging the run.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic to);
        int n;
        to = 1'b1;
        q = 32'h0;
        err = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                q = prdata;
                err = pslverr;
                to = 1'b0;
                break;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

//--- testbench/test_identify_timing_security_words.sv
// Self-checking bench for the identify word register bank.
// Assumes the host model drives APB and cmd_abort is a one-cycle pulse.
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %0t: got %0h expected %0h", $time, g, e); end end
module test_identify_timing_security_words;
    timeunit 1ns;
    timeprecision 100ps;
    import ident_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, cmd_abort;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int n_fail = 0;
    int tests_run = 0;
    int n_abort = 0;
    always #50 pclk = ~pclk;
    always @(posedge pclk) if (cmd_abort === 1'b1) n_abort++;
    ident_words dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmd_abort(cmd_abort));
    apb_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // -----------------------------------------------------------------
    // Bus helpers
    // -----------------------------------------------------------------
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
        logic to;
        host_u.xfer(w, a, d, q, err, to);
        if (to) begin
            n_fail++;
            $display("ERROR %0t: no pready", $time);
            results();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic err;
        xf(1'b1, a, d, q, err);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        logic err;
        xf(1'b0, a, 32'h0, q, err);
        `CHK(q, e)
    endtask
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_fixed();
        rd(OFF_W88, 32'h0); // reset
        rd(OFF_W169, 32'h0000_0001); // trim bit
        rd(OFF_W87, 32'h0000_4000); // valid marker
        rd(OFF_SEC_STAT, 32'h0000_000A); // attempts
    endtask
    task automatic t_words();
        wr(OFF_MPW_REV, 32'h0000_FFFE);
        rd(OFF_W92, 32'h0000_FFFE); // revision
        // Loaded maximum address carries into the upper word once one is added.
        wr(OFF_LBA_LO, 32'hFFFF_FFFF);
        wr(OFF_LBA_HI, 32'h0000_0001);
        rd(OFF_W100, 32'h0); // low half
        rd(OFF_W102, 32'h0000_0002); // high half
        rd(OFF_W105, 32'h0); // no limit
        wr(OFF_TRIM_LIM, 32'h0000_0008);
        rd(OFF_W105, 32'h0000_0008); // limit
        wr(OFF_POWER, 32'h0000_F123);
        rd(OFF_W160, 32'h0000_B123); // power fields
    endtask
    task automatic t_timing();
        wr(OFF_ADV_IDE, 32'h0000_F44A);
        rd(OFF_W163, 32'h0000_044A); // fields
        wr(OFF_ADV_IDE, 32'h0000_044B);
        rd(OFF_W163, 32'h0000_044A); // reserved code
        wr(OFF_ADV_PC, 32'h0000_EB1A);
        rd(OFF_W164, 32'h0000_EB1A); // fields
        wr(OFF_ADV_PC, 32'h0000_EB1C);
        rd(OFF_W164, 32'h0000_EB1A); // reserved code
    endtask
    task automatic t_udma();
        int k;
        for (k = 0; k < 7; k++) begin
            wr(OFF_MODE, 32'((k << 2) | 3));
            wr(OFF_XFER, 32'(8 | k));
            rd(OFF_W88, ((32'h1 << (k + 1)) - 1) | (32'h1 << (8 + k))); // modes
        end
        wr(OFF_MODE, 32'h0000_000B);
        wr(OFF_XFER, 32'h0000_001D);
        rd(OFF_W88, 32'h0000_0007); // multiword wins
        rd(OFF_W163, 32'h0000_044A); // multiword shown
        wr(OFF_XFER, 32'h0000_0009);
        rd(OFF_W88, 32'h0000_0207); // ultra selected
        rd(OFF_W163, 32'h0000_004A); // multiword hidden
        // An Ultra DMA mode above the supported maximum leaves the selection alone.
        wr(OFF_XFER, 32'h0000_000E);
        rd(OFF_W88, 32'h0000_0207); // unsupported mode ignored
        rd(OFF_XFER, 32'h0000_0009); // selection kept
        wr(OFF_MODE, 32'h0000_000A);
        rd(OFF_W88, 32'h0); // not true ide
        wr(OFF_MODE, 32'h0000_0009);
        rd(OFF_W88, 32'h0); // no ultra support
        rd(OFF_MODE, 32'h0000_0009); // mode readback
        wr(OFF_MODE, 32'h0000_001F);
        rd(OFF_MODE, 32'h0000_001B); // maximum clamped
        rd(OFF_W88, 32'h0000_027F); // all modes supported
        wr(OFF_XFER, 32'h0);
        rd(OFF_W88, 32'h0000_007F); // nothing selected
    endtask
    task automatic t_sec();
        logic [15:0] sexp [6] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0000, 16'h0020};
        int i;
        for (i = 0; i < 6; i++) begin
            wr(OFF_SEC_CTRL, 32'h1 << i);
            rd(OFF_W128, {16'h0, sexp[i]}); // status bits
        end
        wr(OFF_SEC_CTRL, 32'h0000_0012);
        rd(OFF_W128, 32'h0000_0102); // maximum level
        wr(OFF_SEC_CTRL, 32'h0000_0002);
        rd(OFF_W128, 32'h0000_0002); // high level
        wr(OFF_SEC_CMD, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        `CHK(n_abort, 0) // unlock allowed
        for (i = 0; i < 5; i++) begin
            rd(OFF_W128, 32'h0000_0002); // not yet expired
            wr(OFF_SEC_CMD, 32'h0000_0001);
        end
        rd(OFF_W128, 32'h0000_0012); // expired flag
        rd(OFF_SEC_STAT, 32'h0000_0001); // counter empty
        wr(OFF_SEC_CMD, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        `CHK(n_abort, 1) // unlock aborted
        wr(OFF_SEC_CMD, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        `CHK(n_abort, 2) // erase aborted
        rd(OFF_SEC_STAT, 32'h0000_0021); // refusal recorded
        wr(OFF_SEC_STAT, 32'h0000_0020);
        rd(OFF_SEC_STAT, 32'h0000_0001); // record cleared, expiry kept
        do_reset();
        rd(OFF_W128, 32'h0); // cleared by reset
        rd(OFF_SEC_STAT, 32'h0000_000A); // counter reloaded
    endtask
    task automatic t_refuse();
        logic [31:0] q;
        logic err;
        xf(1'b0, 8'hFC, 32'h0, q, err);
        `CHK({err, q}, 33'h1_0000_0000) // unmapped read
        wr(OFF_LBA_LO, 32'h0000_0010);
        wr(OFF_LBA_HI, 32'h0);
        xf(1'b1, OFF_W100, 32'h5555_5555, q, err);
        `CHK(err, 1'b1) // read-only word
        rd(OFF_W100, 32'h0000_0011); // unchanged
    endtask
    // -----------------------------------------------------------------
    // Closing report
    // -----------------------------------------------------------------
    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_fixed();
        t_words();
        t_timing();
        t_udma();
        t_sec();
        t_refuse();
        results();
    end
endmodule
